// ==== rtl/dtx_pkg.sv ====
// Types and shared decode function of the dual timer control.
package dtx_pkg;
   // Eight-bit register value.
   typedef logic [7:0] dtx_byte_t;
   // Register selected by a bus address.
   typedef enum logic [3:0] {
      DTX_REG_NONE, DTX_REG_E_COUNT, DTX_REG_E_DATA, DTX_REG_CASCADE, DTX_REG_E_RUN,
      DTX_REG_E_MODE, DTX_REG_F_COUNT, DTX_REG_F_DATA, DTX_REG_F_RUN, DTX_REG_F_MODE
   } dtx_reg_e;
   // Returns {start, stop} qualifiers for the edge selection and the sampled edges.
   function automatic logic [1:0] dtx_edge_dec(input logic [1:0] sel, input logic rise,
                                               input logic fall);
      logic [1:0] res;
      res = 2'h0;
      unique case (sel)
         2'h0: res = {rise, rise};
         2'h1: res = {fall, rise};
         2'h2: res = {rise, fall};
         2'h3: res = {fall, fall};
      endcase
      return res;
   endfunction : dtx_edge_dec
endpackage : dtx_pkg

// ==== rtl/dtx_regs.svh ====
// Register indices, field positions, masks and reset values of the dual timer control.
`ifndef DTX_REGS_SVH
`define DTX_REGS_SVH
// ----------------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------------
`define DTX_IDX_E_COUNT 16'hF360
`define DTX_IDX_E_DATA 16'hF361
`define DTX_IDX_CASCADE 16'hF362
`define DTX_IDX_E_RUN 16'hF363
`define DTX_IDX_E_MODE 16'hF364
`define DTX_IDX_F_COUNT 16'hF368
`define DTX_IDX_F_DATA 16'hF369
`define DTX_IDX_F_RUN 16'hF36B
`define DTX_IDX_F_MODE 16'hF36C
// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define DTX_RUN_BIT 0
`define DTX_TGEN_BIT 1
`define DTX_STAT_BIT 7
`define DTX_CASC_BIT 2
`define DTX_ACT_LSB 0
`define DTX_EDGE_LSB 4
`define DTX_INV_BIT 6
`define DTX_OST_BIT 7
// ----------------------------------------------------------------------
// Writable masks and reset values.
// ----------------------------------------------------------------------
`define DTX_E_MODE_MASK 8'hB3
`define DTX_F_MODE_MASK 8'hF3
`define DTX_CTRL_RESET 8'h00
`endif

// ==== rtl/dtx_timer.sv ====
// One 8-bit interval timer channel with external start and stop.
`timescale 1ns/100ps
module dtx_timer (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Timer clock falling-edge strobe and cascade chain.
   input wire logic tick,
   input wire logic casc,
   input wire logic inc_pulse,
   // Software access.
   input wire logic run_wr,
   input wire logic run_wdata,
   input wire logic cnt_wr,
   input wire dtx_pkg::dtx_byte_t cnt_wdata,
   input wire dtx_pkg::dtx_byte_t data_val,
   // Mode settings and trigger input.
   input wire logic trig_en,
   input wire logic [1:0] action,
   input wire logic [1:0] edge_sel,
   input wire logic one_shot,
   input wire logic trig_in,
   // State and events.
   output logic run_q,
   output logic stat_q,
   output dtx_pkg::dtx_byte_t count_q,
   output logic match_p,
   output logic stop_p,
   output logic tog_q
);
   import dtx_pkg::*;
   logic samp_q, samp_d; // Previous trigger sample.
   logic run_d, stat_d, match_d, stop_d, tog_d;
   dtx_byte_t count_d;
   logic [1:0] qual; // Start and stop qualifiers of this sample.
   logic ext, hw_start, hw_stop, step, hit;

   // Next state of the channel; hardware start and stop win over a software write.
   always_comb begin
      samp_d = tick ? trig_in : samp_q;
      qual = dtx_edge_dec(edge_sel, trig_in & ~samp_q, ~trig_in & samp_q);
      ext = tick & trig_en & ~casc;
      hw_start = ext & action[0] & qual[1] & ~run_q & ~stat_q;
      hw_stop = ext & action[1] & qual[0] & run_q & stat_q;
      step = casc ? inc_pulse : (tick & stat_q);
      hit = step & (count_q == data_val);
      count_d = count_q;
      if (cnt_wr) begin
         count_d = cnt_wdata;
      end else if (step) begin
         count_d = hit ? 8'h00 : count_q + 8'h01;
      end
      run_d = run_wr ? run_wdata : run_q;
      if (hw_start) begin
         run_d = 1'b1;
      end
      if (hw_stop || (hit && one_shot && !casc)) begin
         run_d = 1'b0;
      end
      stat_d = casc ? 1'b0 : (tick ? run_q : stat_q);
      stop_d = hw_stop;
      match_d = hit;
      tog_d = tog_q;
      if (one_shot && !casc) begin
         if (tick && run_q && !stat_q) begin
            tog_d = 1'b1;
         end
         if (hit) begin
            tog_d = 1'b0;
         end
      end else if (hit) begin
         tog_d = ~tog_q;
      end
      // The output returns to idle once the count has halted.
      if (!casc && !stat_q && !run_q) begin
         tog_d = 1'b0;
      end
   end

   // State registers.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         samp_q <= 1'b0;
         run_q <= 1'b0;
         stat_q <= 1'b0;
         count_q <= 8'h00;
         match_p <= 1'b0;
         stop_p <= 1'b0;
         tog_q <= 1'b0;
      end else begin
         samp_q <= samp_d;
         run_q <= run_d;
         stat_q <= stat_d;
         count_q <= count_d;
         match_p <= match_d;
         stop_p <= stop_d;
         tog_q <= tog_d;
      end
   end

   chk_stat_follow: assert property (@(posedge hclk) disable iff (!hresetn)
      tick && !casc |=> stat_q == $past(run_q)) else $error("status did not follow run");
   chk_hw_start: assert property (@(posedge hclk) disable iff (!hresetn)
      hw_start |=> run_q ##1 !tick || stat_q) else $error("external start lost");
   chk_ext_stop: assert property (@(posedge hclk) disable iff (!hresetn)
      hw_stop |=> stop_p && !run_q) else $error("external stop without event");
   chk_reload_run: assert property (@(posedge hclk) disable iff (!hresetn)
      hit && run_q && !one_shot && !run_wr && !hw_stop && !cnt_wr |=> run_q && count_q == 8'h00)
      else $error("auto-reload match changed run");
   chk_oneshot_run: assert property (@(posedge hclk) disable iff (!hresetn)
      hit && one_shot && !casc |=> !run_q && match_p) else $error("one-shot run not cleared");
endmodule : dtx_timer

// ==== rtl/dtx_top.sv ====
// Dual 8-bit timer control with external start/stop and an AHB-Lite register slave.
// Functional notes
// - Run bit zero starts, stops counting.
// - Trigger enable bit one, resets zero.
// - Status bit seven shows counting.
// - Auto-reload: trigger stop clears run, match keeps.
// - One-shot: run reads zero after both.
// - Cascade: F counts on E overflow.
// - Cascade: F status reads zero.
// - Action field: none, start, stop, both.
// - Edge field picks start and stop edges.
// - External stop raises the interrupt.
// - Mode bit seven selects one-shot.
// - F output polarity bit six.
// - Cascade ignores F action, edge, one-shot.
// - Control registers eight bits, reset zero.
// - Triggers sampled on timer clock strobe.
// - Qualifying start edge sets run bit.
// - Status first tick, count second tick.
// - One-shot match clears run bit.
`timescale 1ns/100ps
`include "dtx_regs.svh"
module dtx_top (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata_q,
   output logic hreadyout_q,
   output logic hresp_q,
   // Timer clock strobes, one per falling edge of each selected timer clock.
   input wire logic e_tick,
   input wire logic f_tick,
   // External trigger inputs, already routed from the selected pins.
   input wire logic e_trig_in,
   input wire logic f_trig_in,
   // Interrupt requests and timer F output.
   output logic e_irq_q,
   output logic f_irq_q,
   output logic f_toggle_output_q
);
   import dtx_pkg::*;

   // ----------------------------------------------------------------------
   // Register state.
   // ----------------------------------------------------------------------
   logic e_trigger_enable_q, e_trigger_enable_d; // Timer E trigger enable.
   logic f_trigger_enable_q, f_trigger_enable_d; // Timer F trigger enable.
   dtx_byte_t e_mode_q, e_mode_d; // Timer E trigger and mode register.
   dtx_byte_t f_mode_q, f_mode_d; // Timer F trigger and mode register.
   dtx_byte_t e_data_q, e_data_d; // Timer E compare value.
   dtx_byte_t f_data_q, f_data_d; // Timer F compare value.
   logic cascade_16bit_select_q, cascade_16bit_select_d; // Joins the timers.

   // ----------------------------------------------------------------------
   // Bus phase state.
   // ----------------------------------------------------------------------
   logic wr_pend_q, wr_pend_d; // A write data phase is in progress.
   dtx_reg_e wsel_q, wsel_d; // Register targeted by that write.
   logic [31:0] hrdata_d;
   logic e_irq_d, f_irq_d, f_out_d;

   // ----------------------------------------------------------------------
   // Channel wiring.
   // ----------------------------------------------------------------------
   logic e_run, e_stat, e_match, e_stop, e_tog;
   logic f_run, f_stat, f_match, f_stop, f_tog;
   dtx_byte_t e_count, f_count;
   logic addr_take; // Address phase accepted this cycle.
   dtx_reg_e rsel; // Register decoded from the current address.
   logic [7:0] wbyte; // Low byte of the write data.
   logic e_run_wr, f_run_wr, e_cnt_wr, f_cnt_wr;
   logic f_trig_gate; // Trigger enable of F as the channel sees it.
   logic f_ost_gate; // One-shot of F as the channel sees it.
   logic [1:0] f_act_gate; // Action field of F as the channel sees it.

   // Maps a word address onto a register, or none when unmapped.
   function automatic dtx_reg_e dtx_decode(input logic [31:0] addr);
      dtx_reg_e r;
      r = DTX_REG_NONE;
      if (addr[31:18] == 14'h0000 && addr[1:0] == 2'h0) begin
         unique case (addr[17:2])
            `DTX_IDX_E_COUNT: r = DTX_REG_E_COUNT;
            `DTX_IDX_E_DATA: r = DTX_REG_E_DATA;
            `DTX_IDX_CASCADE: r = DTX_REG_CASCADE;
            `DTX_IDX_E_RUN: r = DTX_REG_E_RUN;
            `DTX_IDX_E_MODE: r = DTX_REG_E_MODE;
            `DTX_IDX_F_COUNT: r = DTX_REG_F_COUNT;
            `DTX_IDX_F_DATA: r = DTX_REG_F_DATA;
            `DTX_IDX_F_RUN: r = DTX_REG_F_RUN;
            `DTX_IDX_F_MODE: r = DTX_REG_F_MODE;
            default: r = DTX_REG_NONE;
         endcase
      end
      return r;
   endfunction : dtx_decode

   // Builds the read value of a register; unused bits read as zero.
   function automatic dtx_byte_t dtx_read(input dtx_reg_e r);
      dtx_byte_t v;
      v = 8'h00;
      unique case (r)
         DTX_REG_NONE: v = 8'h00;
         DTX_REG_E_COUNT: v = e_count;
         DTX_REG_E_DATA: v = e_data_q;
         DTX_REG_CASCADE: v[`DTX_CASC_BIT] = cascade_16bit_select_q;
         DTX_REG_E_RUN: begin
            v[`DTX_STAT_BIT] = e_stat;
            v[`DTX_TGEN_BIT] = e_trigger_enable_q;
            v[`DTX_RUN_BIT] = e_run;
         end
         DTX_REG_E_MODE: v = e_mode_q;
         DTX_REG_F_COUNT: v = f_count;
         DTX_REG_F_DATA: v = f_data_q;
         DTX_REG_F_RUN: begin
            v[`DTX_STAT_BIT] = f_stat & ~cascade_16bit_select_q;
            v[`DTX_TGEN_BIT] = f_trigger_enable_q;
            v[`DTX_RUN_BIT] = f_run;
         end
         DTX_REG_F_MODE: v = f_mode_q;
      endcase
      return v;
   endfunction : dtx_read

   // ----------------------------------------------------------------------
   // Bus slave.
   // ----------------------------------------------------------------------

   // Address phase capture and read data; the slave never inserts wait states.
   // A read that directly follows a write to the same register returns the
   // value from before that write, since both happen at the same edge.
   always_comb begin
      addr_take = hsel & hready & htrans[1];
      rsel = dtx_decode(haddr);
      wbyte = hwdata[7:0];
      wr_pend_d = addr_take & hwrite;
      wsel_d = (addr_take && hwrite) ? rsel : DTX_REG_NONE;
      hrdata_d = hrdata_q;
      if (addr_take && !hwrite) begin
         hrdata_d = {24'h000000, dtx_read(rsel)};
      end
   end

   // Software write strobes handed to the channels in the write data phase.
   always_comb begin
      e_run_wr = wr_pend_q & (wsel_q == DTX_REG_E_RUN);
      f_run_wr = wr_pend_q & (wsel_q == DTX_REG_F_RUN);
      e_cnt_wr = wr_pend_q & (wsel_q == DTX_REG_E_COUNT);
      f_cnt_wr = wr_pend_q & (wsel_q == DTX_REG_F_COUNT);
   end

   // Control register updates; masks keep reserved bits at zero.
   always_comb begin
      e_trigger_enable_d = e_trigger_enable_q;
      f_trigger_enable_d = f_trigger_enable_q;
      e_mode_d = e_mode_q;
      f_mode_d = f_mode_q;
      e_data_d = e_data_q;
      f_data_d = f_data_q;
      cascade_16bit_select_d = cascade_16bit_select_q;
      if (wr_pend_q) begin
         unique case (wsel_q)
            DTX_REG_E_RUN: e_trigger_enable_d = wbyte[`DTX_TGEN_BIT];
            DTX_REG_F_RUN: f_trigger_enable_d = wbyte[`DTX_TGEN_BIT];
            DTX_REG_E_MODE: e_mode_d = wbyte & `DTX_E_MODE_MASK;
            DTX_REG_F_MODE: f_mode_d = wbyte & `DTX_F_MODE_MASK;
            DTX_REG_E_DATA: e_data_d = wbyte;
            DTX_REG_F_DATA: f_data_d = wbyte;
            DTX_REG_CASCADE: cascade_16bit_select_d = wbyte[`DTX_CASC_BIT];
            // Counts and unmapped words are handled elsewhere or ignored.
            DTX_REG_NONE, DTX_REG_E_COUNT, DTX_REG_F_COUNT: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Channel control.
   // ----------------------------------------------------------------------

   // In cascade mode the F trigger, edge, action and one-shot settings are dead.
   always_comb begin
      f_trig_gate = f_trigger_enable_q & ~cascade_16bit_select_q;
      f_act_gate = cascade_16bit_select_q ? 2'h0 : f_mode_q[`DTX_ACT_LSB +: 2];
      f_ost_gate = f_mode_q[`DTX_OST_BIT] & ~cascade_16bit_select_q;
   end

   // Timer E channel; it is the low half in cascade mode.
   // Sampling on timer strobe.
   dtx_timer u_timer_e (
      .hclk(hclk),
      .hresetn(hresetn),
      .tick(e_tick),
      .casc(1'b0),
      .inc_pulse(1'b0),
      .run_wr(e_run_wr),
      .run_wdata(wbyte[`DTX_RUN_BIT]),
      .cnt_wr(e_cnt_wr),
      .cnt_wdata(wbyte),
      .data_val(e_data_q),
      .trig_en(e_trigger_enable_q),
      .action(e_mode_q[`DTX_ACT_LSB +: 2]),
      .edge_sel(e_mode_q[`DTX_EDGE_LSB +: 2]),
      .one_shot(e_mode_q[`DTX_OST_BIT]),
      .trig_in(e_trig_in),
      .run_q(e_run),
      .stat_q(e_stat),
      .count_q(e_count),
      .match_p(e_match),
      .stop_p(e_stop),
      .tog_q(e_tog)
   );

   // Timer F channel; in cascade mode it counts each timer E overflow.
   // E overflow drives F.
   dtx_timer u_timer_f (
      .hclk(hclk),
      .hresetn(hresetn),
      .tick(f_tick),
      .casc(cascade_16bit_select_q),
      .inc_pulse(e_match),
      .run_wr(f_run_wr),
      .run_wdata(wbyte[`DTX_RUN_BIT]),
      .cnt_wr(f_cnt_wr),
      .cnt_wdata(wbyte),
      .data_val(f_data_q),
      .trig_en(f_trig_gate),
      .action(f_act_gate),
      .edge_sel(f_mode_q[`DTX_EDGE_LSB +: 2]),
      .one_shot(f_ost_gate),
      .trig_in(f_trig_in),
      .run_q(f_run),
      .stat_q(f_stat),
      .count_q(f_count),
      .match_p(f_match),
      .stop_p(f_stop),
      .tog_q(f_tog)
   );

   // Interrupt pulses and the timer F output level.
   always_comb begin
      e_irq_d = (e_match & ~cascade_16bit_select_q) | e_stop;
      f_irq_d = f_match | f_stop;
      f_out_d = f_tog ^ f_mode_q[`DTX_INV_BIT];
   end

   // ----------------------------------------------------------------------
   // Registers.
   // ----------------------------------------------------------------------

   // All control state and every top output are registered here.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         e_trigger_enable_q <= 1'b0;
         f_trigger_enable_q <= 1'b0;
         e_mode_q <= `DTX_CTRL_RESET;
         f_mode_q <= `DTX_CTRL_RESET;
         e_data_q <= `DTX_CTRL_RESET;
         f_data_q <= `DTX_CTRL_RESET;
         cascade_16bit_select_q <= 1'b0;
         wr_pend_q <= 1'b0;
         wsel_q <= DTX_REG_NONE;
         hrdata_q <= 32'h00000000;
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
         e_irq_q <= 1'b0;
         f_irq_q <= 1'b0;
         f_toggle_output_q <= 1'b0;
      end else begin
         e_trigger_enable_q <= e_trigger_enable_d;
         f_trigger_enable_q <= f_trigger_enable_d;
         e_mode_q <= e_mode_d;
         f_mode_q <= f_mode_d;
         e_data_q <= e_data_d;
         f_data_q <= f_data_d;
         cascade_16bit_select_q <= cascade_16bit_select_d;
         wr_pend_q <= wr_pend_d;
         wsel_q <= wsel_d;
         hrdata_q <= hrdata_d;
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
         e_irq_q <= e_irq_d;
         f_irq_q <= f_irq_d;
         f_toggle_output_q <= f_out_d;
      end
   end

   // ----------------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------------

   chk_casc_status: assert property (@(posedge hclk) disable iff (!hresetn)
      addr_take && !hwrite && rsel == DTX_REG_F_RUN && cascade_16bit_select_q
      |=> hrdata_q[`DTX_STAT_BIT] == 1'b0) else $error("F status visible in cascade");
   chk_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      addr_take && !hwrite && (rsel == DTX_REG_E_RUN || rsel == DTX_REG_F_RUN)
      |=> hrdata_q[6:2] == 5'h00 && hrdata_q[31:8] == 24'h000000)
      else $error("reserved bits not zero");
   chk_stop_irq: assert property (@(posedge hclk) disable iff (!hresetn)
      e_stop || f_stop |=> e_irq_q || f_irq_q) else $error("stop without interrupt");
   chk_tgen_write: assert property (@(posedge hclk) disable iff (!hresetn)
      e_run_wr |=> e_trigger_enable_q == $past(wbyte[`DTX_TGEN_BIT]))
      else $error("trigger enable not written");
   chk_out_polarity: assert property (@(posedge hclk) disable iff (!hresetn)
      ##1 f_toggle_output_q == ($past(f_tog) ^ $past(f_mode_q[`DTX_INV_BIT])))
      else $error("F output polarity wrong");
endmodule : dtx_top

// ==== verif/dtx_top_tb_top.sv ====
// Self-checking testbench of the dual timer control.
`timescale 1ns/100ps
`include "dtx_regs.svh"
module dtx_top_tb_top;
   // ----------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, tick = 1'b0;
   logic e_want = 1'b0, f_want = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata_q;
   logic [1:0] htrans = 2'h0;
   logic hreadyout_q, hresp_q, e_irq_q, f_irq_q, f_toggle_output_q, e_trig, f_trig;
   int failures = 0, check_count = 0, e_irqs = 0, f_irqs = 0, tdiv = 0;
   dtx_top dtx_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout_q),
      .hrdata_q(hrdata_q), .hreadyout_q(hreadyout_q), .hresp_q(hresp_q), .e_tick(tick),
      .f_tick(tick), .e_trig_in(e_trig), .f_trig_in(f_trig), .e_irq_q(e_irq_q),
      .f_irq_q(f_irq_q), .f_toggle_output_q(f_toggle_output_q));
   dtx_trig_src e_src_i (.hclk(hclk), .tick(tick), .want(e_want), .trig_q(e_trig));
   dtx_trig_src f_src_i (.hclk(hclk), .tick(tick), .want(f_want), .trig_q(f_trig));
   // Clock, a timer strobe every fourth cycle, and the E and F interrupt pulse counters.
   always #10 hclk = ~hclk;
   always @(posedge hclk) begin
      tdiv <= (tdiv + 1) % 4;
      tick <= (tdiv == 3);
      if (e_irq_q === 1'b1) e_irqs++;
      if (f_irq_q === 1'b1) f_irqs++;
   end
   // ----------------------------------------
   // Bus and check tasks
   // ----------------------------------------
   function automatic logic [31:0] ba(input logic [15:0] idx);
      return {14'h0, idx, 2'h0};
   endfunction : ba
   task automatic xfer(input logic [15:0] idx, input logic wr, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= ba(idx);
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout_q !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout_q !== 1'b1);
   endtask : xfer
   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      xfer(idx, 1'b1, {24'h0, d});
   endtask : wr
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // Reads stand on hrdata_q after the data phase, so sampling here is safe.
   task automatic rd(input string name, input logic [15:0] idx, input logic [31:0] exp);
      xfer(idx, 1'b0, 32'h0);
      check(name, hrdata_q, exp);
      check("hresp", hresp_q, 32'h0);
   endtask : rd
   task automatic wt(input int n);
      repeat (n * 4) @(posedge hclk);
   endtask : wt
   task automatic summarize();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      rd("e_run", `DTX_IDX_E_RUN, 32'h0);
      rd("e_mode", `DTX_IDX_E_MODE, 32'h0);
      rd("f_run", `DTX_IDX_F_RUN, 32'h0);
      rd("f_mode", `DTX_IDX_F_MODE, 32'h0);
      rd("unmapped", 16'h0, 32'h0);
      wr(`DTX_IDX_E_MODE, 8'hFF);
      rd("e_mode_mask", `DTX_IDX_E_MODE, 32'hB3);
      wr(`DTX_IDX_F_MODE, 8'hFF);
      rd("f_mode_mask", `DTX_IDX_F_MODE, 32'hF3);
      check("f_out_neg", f_toggle_output_q, 1'b1);
      wr(`DTX_IDX_F_MODE, 8'h00);
      wr(`DTX_IDX_E_MODE, 8'h00);
      check("f_out_pos", f_toggle_output_q, 1'b0);
      $display("registers done");
   endtask : t_regs
   // Auto-reload match keeps run set, a software stop clears status.
   task automatic t_reload();
      int n;
      wr(`DTX_IDX_E_COUNT, 8'h00);
      wr(`DTX_IDX_E_DATA, 8'h02);
      n = e_irqs;
      wr(`DTX_IDX_E_RUN, 8'h01);
      wt(12);
      check("match_irq", e_irqs > n, 1);
      rd("run_kept", `DTX_IDX_E_RUN, 32'h81);
      wr(`DTX_IDX_E_RUN, 8'h00);
      wt(3);
      rd("halted", `DTX_IDX_E_RUN, 32'h00);
      $display("reload done");
   endtask : t_reload
   // One-shot match clears run after a single interrupt.
   task automatic t_oneshot();
      int n;
      wr(`DTX_IDX_E_MODE, 8'h80);
      wr(`DTX_IDX_E_COUNT, 8'h00);
      n = e_irqs;
      wr(`DTX_IDX_E_RUN, 8'h01);
      wt(12);
      check("one_irq", e_irqs, n + 1);
      rd("run_clr", `DTX_IDX_E_RUN, 32'h00);
      wr(`DTX_IDX_E_MODE, 8'h00);
      $display("oneshot done");
   endtask : t_oneshot
   // Every edge code: start on its start edge, stop on its stop edge with one interrupt.
   task automatic t_edges();
      int n;
      for (int s = 0; s < 4; s++) begin
         wr(`DTX_IDX_E_COUNT, 8'h00);
         wr(`DTX_IDX_E_DATA, 8'hFF);
         // Mode written only while fully stopped.
         wr(`DTX_IDX_E_MODE, {2'h0, 2'(s), 4'h3});
         e_want <= s[0];
         wt(4);
         n = e_irqs;
         wr(`DTX_IDX_E_RUN, 8'h02);
         e_want <= ~s[0];
         wt(4);
         rd("trig_start", `DTX_IDX_E_RUN, 32'h83);
         e_want <= s[0];
         wt(4);
         if (e_irqs == n) begin
            e_want <= ~s[0];
            wt(4);
         end
         check("stop_irq", e_irqs, n + 1);
         // Let the status settle to zero before going on.
         wt(2);
         rd("trig_stop", `DTX_IDX_E_RUN, 32'h02);
         wr(`DTX_IDX_E_RUN, 8'h00);
      end
      $display("edges done");
   endtask : t_edges
   // Cascade: F counts on E overflow with run clear, its status reads zero.
   task automatic t_cascade();
      int n;
      logic [31:0] cnt;
      wr(`DTX_IDX_F_COUNT, 8'h00);
      // A full-scale compare value keeps F from matching and reloading to zero.
      wr(`DTX_IDX_F_DATA, 8'hFF);
      wr(`DTX_IDX_CASCADE, 8'h04);
      wr(`DTX_IDX_E_COUNT, 8'h00);
      wr(`DTX_IDX_E_DATA, 8'h01);
      n = e_irqs;
      wr(`DTX_IDX_E_RUN, 8'h01);
      wt(12);
      rd("f_stat", `DTX_IDX_F_RUN, 32'h00);
      xfer(`DTX_IDX_F_COUNT, 1'b0, 32'h0);
      cnt = hrdata_q;
      check("f_counts", cnt != 32'h0, 1);
      check("e_irq_off", e_irqs, n);
      wr(`DTX_IDX_E_RUN, 8'h00);
      $display("cascade done");
   endtask : t_cascade
   // Timer F: trigger start, then trigger stop with one F interrupt.
   task automatic t_fstop();
      int n;
      wr(`DTX_IDX_F_COUNT, 8'h00);
      wr(`DTX_IDX_F_DATA, 8'hFF);
      wr(`DTX_IDX_F_MODE, 8'h03);
      n = f_irqs;
      wr(`DTX_IDX_F_RUN, 8'h02);
      f_want <= 1'b1;
      wt(4);
      rd("f_trig_start", `DTX_IDX_F_RUN, 32'h83);
      f_want <= 1'b0;
      wt(2);
      f_want <= 1'b1;
      wt(5);
      check("f_stop_irq", f_irqs, n + 1);
      rd("f_trig_stop", `DTX_IDX_F_RUN, 32'h02);
      // F run and trigger enable cleared before cascading.
      wr(`DTX_IDX_F_RUN, 8'h00);
      $display("f stop done");
   endtask : t_fstop
   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_reload();
      t_oneshot();
      t_edges();
      t_fstop();
      t_cascade();
      summarize();
   end
   // The tests need well under ten thousand cycles; this margin only catches a hang.
   initial begin
      #400000;
      failures++;
      summarize();
   end
endmodule : dtx_top_tb_top

// ==== verif/dtx_trig_src.sv ====
// Model of the external trigger source that drives one timer trigger input.
`timescale 1ns/100ps
module dtx_trig_src (
   // Clock and timer clock strobe.
   input wire logic hclk,
   input wire logic tick,
   // Level that the bench asks for.
   input wire logic want,
   // Trigger level seen by the timer.
   output logic trig_q
);
   // ----------------------------------------
   // Trigger level
   // ----------------------------------------
   // Whole sample periods.
   // The level only moves on a strobe, so no pulse is shorter than one sample.
   // A plain process is used because the level also has a start value below.
   always @(posedge hclk) begin
      if (tick) begin
         trig_q <= want;
      end
   end
   initial trig_q = 1'b0;
endmodule : dtx_trig_src
